// ---- common/hmp_pkg.sv ----
package hmp_pkg;

	// Master clock is the oscillator divided by three
	localparam int CLK_DIV = 3;
	localparam logic [1:0] DIV_LAST = 2'h2;

	// Oscillator settling, counted in CPU clock cycles
	localparam int STAB_CPU_CYCLES = 4096;

	// Wake sources: external lines plus the USB end-of-suspend
	localparam int EXT_LINES = 4;
	localparam int SRC_COUNT = 5;
	localparam logic [2:0] SRC_USB = 3'h4;

	// Stack pointer and frame sizes
	localparam int SP_W = 10;
	localparam logic [9:0] SP_RESET = 10'h03ff;
	localparam logic [9:0] IRQ_FRAME = 10'h0005;
	localparam logic [9:0] CALL_FRAME = 10'h0002;

	// Global interrupt mask after reset
	localparam logic I_MASK_RESET = 1'b1;

	typedef enum logic [1:0] {
		HMP_RUN,
		HMP_HALT,
		HMP_STAB
	} hmp_state_t;

endpackage

// ---- common/hmp_stab_if.sv ----
`timescale 1ns/1ps
interface hmp_stab_if;
	logic start;
	logic tick;
	logic done;
	logic busy;
	modport ctrl (output start, output tick, input done, input busy);
	modport timer (input start, input tick, output done, output busy);
endinterface

// ---- src/hmp_stab_timer.sv ----
`timescale 1ns/1ps
module hmp_stab_timer #(
	parameter int STAB_CYCLES = hmp_pkg::STAB_CPU_CYCLES
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Link to the controller
	hmp_stab_if.timer s
);

	localparam int CW = $clog2(STAB_CYCLES);
	localparam logic [CW-1:0] LAST = CW'(STAB_CYCLES - 1);

	logic [CW-1:0] cnt;

	////////////////////////////////////////////////////////////////////////
	// Count CPU ticks; a new start restarts the whole delay
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			cnt <= '0;
			s.busy <= 1'b0;
		end else if (s.start) begin
			cnt <= '0;
			s.busy <= 1'b1;
		end else if (s.busy && s.tick) begin
			if (cnt == LAST) begin
				s.busy <= 1'b0;
			end else begin
				cnt <= cnt + 1'b1;
			end
		end
	end

	// One-cycle end pulse after the last tick
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			s.done <= 1'b0;
		end else begin
			s.done <= s.busy && s.tick && (cnt == LAST) && !s.start;
		end
	end

endmodule

// ---- src/hmp_halt_ctrl.sv ----
// Behaviour
// - Reset starts settling, then run, CPU clock osc/3
// - Halt entered only by halt instruction
// - Halt switches oscillator off, all stop
// - Halt entry clears global interrupt mask
// - Only external lines, USB, reset wake
// - Wake restarts oscillator, 4096-cycle hold
// - Then service waking interrupt or reset
// - Interrupt pushes five, call pushes two
// - Return pops context, raises stack pointer
`timescale 1ns/1ps
module hmp_halt_ctrl #(
	parameter int STAB_CYCLES = hmp_pkg::STAB_CPU_CYCLES
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,

	// Wake sources
	input wire logic [hmp_pkg::EXT_LINES-1:0] external_interrupt_lines,
	input wire logic usb_end_suspend,

	// Instruction strobes from the CPU core
	input wire logic halt_exec,
	input wire logic call_exec,
	input wire logic ret_exec,
	input wire logic iret_exec,
	input wire logic sei_exec,
	input wire logic cli_exec,

	// Clocking and power state
	output logic osc_en,
	output logic cpu_tick,
	output logic halted,
	output logic settling,

	// CPU context
	output logic i_mask,
	output logic [hmp_pkg::SP_W-1:0] sp,

	// Interrupt and reset vector requests
	output logic irq_take,
	output logic [2:0] irq_src,
	output logic reset_fetch
);

	hmp_stab_if s ();

	hmp_pkg::hmp_state_t state;

	logic [hmp_pkg::EXT_LINES-1:0] sync1;
	logic [hmp_pkg::EXT_LINES-1:0] sync2;
	logic [hmp_pkg::EXT_LINES-1:0] sync3;
	logic [hmp_pkg::EXT_LINES-1:0] ext_lvl;
	logic [hmp_pkg::EXT_LINES-1:0] agree;
	logic [hmp_pkg::EXT_LINES-1:0] ext_evt;
	logic [hmp_pkg::SRC_COUNT-1:0] new_evt;
	logic [hmp_pkg::SRC_COUNT-1:0] pend;
	logic [hmp_pkg::SRC_COUNT-1:0] take_mask;
	logic [1:0] div_cnt;
	logic div_tick;
	logic boot_start;
	logic boot_wake;
	logic wake_any;
	logic take_go;
	logic in_run;
	logic [2:0] next_src;
	logic [hmp_pkg::SP_W-1:0] next_sp;

	////////////////////////////////////////////////////////////////////////
	// Helpers

	// Lowest-numbered pending source wins; USB is last
	function automatic logic [2:0] pick_src(
		input logic [hmp_pkg::SRC_COUNT-1:0] p
	);
		pick_src = 3'h0;
		for (int i = hmp_pkg::SRC_COUNT - 1; i >= 0; i--) begin
			if (p[i]) begin
				pick_src = 3'(i);
			end
		end
	endfunction

	// Move the stack pointer by a frame when the strobe is set
	function automatic logic [hmp_pkg::SP_W-1:0] sp_step(
		input logic [hmp_pkg::SP_W-1:0] v,
		input logic en,
		input logic down,
		input logic [hmp_pkg::SP_W-1:0] frame
	);
		if (!en) begin
			sp_step = v;
		end else if (down) begin
			sp_step = v - frame;
		end else begin
			sp_step = v + frame;
		end
	endfunction

	////////////////////////////////////////////////////////////////////////
	// External line synchroniser

	// Three stages; a level counts once stages two and three agree
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			sync1 <= '0;
			sync2 <= '0;
			sync3 <= '0;
		end else begin
			sync1 <= external_interrupt_lines;
			sync2 <= sync1;
			sync3 <= sync2;
		end
	end

	assign agree = ~(sync2 ^ sync3);

	// Filtered level; a glitch seen by only one stage is dropped
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ext_lvl <= '0;
		end else begin
			ext_lvl <= (ext_lvl & ~agree) | (sync2 & agree);
		end
	end

	// Rising filtered level is the interrupt event
	assign ext_evt = agree & sync2 & ~ext_lvl;
	assign new_evt = {usb_end_suspend, ext_evt};

	////////////////////////////////////////////////////////////////////////
	// Master clock divider

	assign osc_en = (state != hmp_pkg::HMP_HALT);

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			div_cnt <= 2'h0;
		end else if (!osc_en) begin
			div_cnt <= 2'h0;
		end else if (div_cnt == hmp_pkg::DIV_LAST) begin
			div_cnt <= 2'h0;
		end else begin
			div_cnt <= div_cnt + 2'h1;
		end
	end

	assign div_tick = osc_en && (div_cnt == hmp_pkg::DIV_LAST);
	assign in_run = (state == hmp_pkg::HMP_RUN);
	// CPU and peripherals see ticks only in run
	assign cpu_tick = div_tick && in_run;
	assign halted = (state == hmp_pkg::HMP_HALT);
	assign settling = (state == hmp_pkg::HMP_STAB);

	////////////////////////////////////////////////////////////////////////
	// Power state machine

	// Any pending or fresh wake source, regardless of the mask
	assign wake_any = |pend || |new_evt;

	assign s.start = (halted && wake_any) || boot_start;
	assign s.tick = div_tick;

	hmp_stab_timer #(
		.STAB_CYCLES(STAB_CYCLES)
	) u_stab (
		.clk(clk),
		.rst_n(rst_n),
		.s(s)
	);

	// Reset counts as a wake: it also waits out the settling time
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state <= hmp_pkg::HMP_STAB;
		end else begin
			unique case (state)
				hmp_pkg::HMP_RUN: begin
					if (halt_exec) begin
						state <= hmp_pkg::HMP_HALT;
					end
				end
				hmp_pkg::HMP_HALT: begin
					if (wake_any) begin
						state <= hmp_pkg::HMP_STAB;
					end
				end
				hmp_pkg::HMP_STAB: begin
					if (s.done) begin
						state <= hmp_pkg::HMP_RUN;
					end
				end
			endcase
		end
	end

	// Kick the timer once after reset, remember the reset cause
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			boot_start <= 1'b1;
			boot_wake <= 1'b1;
		end else begin
			boot_start <= 1'b0;
			if (settling && s.done) begin
				boot_wake <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			reset_fetch <= 1'b0;
		end else begin
			reset_fetch <= settling && s.done && boot_wake;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Pending wake interrupts and delivery

	assign take_go = cpu_tick && |pend && !i_mask;
	assign next_src = pick_src(pend);
	assign take_mask = take_go ? (5'h01 << next_src) : 5'h00;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			pend <= '0;
		end else begin
			pend <= (pend & ~take_mask) | new_evt;
		end
	end

	// One-cycle request with the source number beside it
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			irq_take <= 1'b0;
			irq_src <= 3'h0;
		end else begin
			irq_take <= take_go;
			if (take_go) begin
				irq_src <= next_src;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Condition code mask and stack pointer

	// Strobes are honoured only while the CPU runs
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			i_mask <= hmp_pkg::I_MASK_RESET;
		end else if (in_run && halt_exec) begin
			i_mask <= 1'b0;
		end else if (take_go || (in_run && sei_exec)) begin
			i_mask <= 1'b1;
		end else if (in_run && (iret_exec || cli_exec)) begin
			i_mask <= 1'b0;
		end
	end

	// All frames of one cycle combine, so no strobe is lost
	always_comb begin
		next_sp = sp;
		next_sp = sp_step(next_sp, take_go, 1'b1, hmp_pkg::IRQ_FRAME);
		next_sp = sp_step(next_sp, in_run && call_exec, 1'b1,
			hmp_pkg::CALL_FRAME);
		next_sp = sp_step(next_sp, in_run && iret_exec, 1'b0,
			hmp_pkg::IRQ_FRAME);
		next_sp = sp_step(next_sp, in_run && ret_exec, 1'b0,
			hmp_pkg::CALL_FRAME);
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			sp <= hmp_pkg::SP_RESET;
		end else begin
			sp <= next_sp;
		end
	end

endmodule

// ---- dv/hmp_halt_ctrl_sva.sv ----
`timescale 1ns/1ps
module hmp_halt_ctrl_sva #(
	parameter int STAB_CYCLES = hmp_pkg::STAB_CPU_CYCLES
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Watched inputs
	input wire logic [hmp_pkg::EXT_LINES-1:0] external_interrupt_lines,
	input wire logic usb_end_suspend,
	input wire logic halt_exec,
	input wire logic call_exec,
	input wire logic ret_exec,
	input wire logic iret_exec,
	// Watched outputs
	input wire logic osc_en,
	input wire logic cpu_tick,
	input wire logic halted,
	input wire logic settling,
	input wire logic i_mask,
	input wire logic [hmp_pkg::SP_W-1:0] sp,
	input wire logic irq_take,
	input wire logic reset_fetch
);
	localparam int LO = 3 * STAB_CYCLES;
	localparam int HI = LO + 4;
	int cnt;
	wire run = !halted && !settling;
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	////////////////////////////////
	// Settling length; slack covers the wake pipeline
	always_ff @(posedge clk) begin
		if (!rst_n || !settling) begin
			cnt <= 0;
		end else begin
			cnt <= cnt + 1;
		end
	end
	sequence s_halt_req;
		halt_exec && run;
	endsequence
	sequence s_asleep;
		halted && !osc_en && !i_mask;
	endsequence
	////////////////////////////////
	a_halt_entry: assert property (s_halt_req |=> s_asleep)
		else $error("halt entry effects missing");
	a_osc_halt: assert property (osc_en == !halted)
		else $error("oscillator state wrong");
	a_tick_gap: assert property (cpu_tick |=> !cpu_tick [*2])
		else $error("cpu tick closer than three");
	a_no_tick: assert property (!run |-> !cpu_tick)
		else $error("cpu tick while stopped");
	a_usb_wake: assert property (halted && usb_end_suspend
		|=> settling && osc_en) else $error("usb did not wake");
	a_no_wake: assert property ((halted && !usb_end_suspend
		&& external_interrupt_lines == 0) [*6] |=> halted)
		else $error("woke without event");
	a_settle_len: assert property ($fell(settling)
		|-> cnt >= LO && cnt <= HI) else $error("settling length");
	a_fetch_end: assert property (reset_fetch
		|-> run && $past(settling) && !irq_take)
		else $error("reset fetch out of place");
	a_irq_push: assert property (irq_take
		&& !$past(call_exec || ret_exec || iret_exec)
		|-> i_mask && $past(cpu_tick)
		&& sp == $past(sp) - hmp_pkg::IRQ_FRAME)
		else $error("interrupt frame wrong");
	a_call_push: assert property (run && i_mask && call_exec
		&& !ret_exec && !iret_exec
		|=> sp == $past(sp) - hmp_pkg::CALL_FRAME)
		else $error("call frame wrong");
	a_iret_pop: assert property (run && i_mask && iret_exec
		&& !call_exec && !ret_exec
		|=> !i_mask && sp == $past(sp) + hmp_pkg::IRQ_FRAME)
		else $error("interrupt return wrong");
endmodule

bind hmp_halt_ctrl hmp_halt_ctrl_sva #(.STAB_CYCLES(STAB_CYCLES)) u_sva (
	.clk(clk), .rst_n(rst_n),
	.external_interrupt_lines(external_interrupt_lines),
	.usb_end_suspend(usb_end_suspend), .halt_exec(halt_exec),
	.call_exec(call_exec), .ret_exec(ret_exec), .iret_exec(iret_exec),
	.osc_en(osc_en), .cpu_tick(cpu_tick), .halted(halted),
	.settling(settling), .i_mask(i_mask), .sp(sp),
	.irq_take(irq_take), .reset_fetch(reset_fetch));

// ---- dv/hmp_cpu_model.sv ----
`timescale 1ns/1ps
module hmp_cpu_model (
	// Clock
	input wire logic clk,
	// Bench requests and handler length
	input wire logic [5:0] op,
	input wire logic [3:0] lat,
	// Design view
	input wire logic irq_take,
	// Strobes: halt, call, ret, iret, sei, cli
	output logic [5:0] strobe
);
	logic auto_iret = 1'b0;
	// handler runs lat cycles, then iret
	always @(posedge clk) begin
		#1;
		if (irq_take === 1'b1) begin
			repeat (lat) @(posedge clk);
			#1 auto_iret = 1'b1;
			@(posedge clk);
			#1 auto_iret = 1'b0;
		end
	end
	// Handler return merged with bench ops
	assign strobe = op | {3'h0, auto_iret, 2'h0};
endmodule

// ---- dv/hmp_halt_ctrl_bench.sv ----
`timescale 1ns/1ps
module hmp_halt_ctrl_bench;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [3:0] ext = 4'h0;
	logic usb = 1'b0;
	logic [5:0] op = 6'h00;
	logic [3:0] lat = 4'h1;
	logic [5:0] stb;
	logic osc_en, cpu_tick, halted, settling, i_mask, irq_take, reset_fetch;
	logic [9:0] sp;
	logic [2:0] irq_src;
	int error_cnt = 0;
	int samples_checked = 0;
	always #4 clk = ~clk;
	hmp_cpu_model cpu (.clk(clk), .op(op), .lat(lat),
		.irq_take(irq_take), .strobe(stb));
	hmp_halt_ctrl #(.STAB_CYCLES(4)) dut (.clk(clk), .rst_n(rst_n),
		.external_interrupt_lines(ext), .usb_end_suspend(usb),
		.halt_exec(stb[5]), .call_exec(stb[4]), .ret_exec(stb[3]),
		.iret_exec(stb[2]), .sei_exec(stb[1]), .cli_exec(stb[0]),
		.osc_en(osc_en), .cpu_tick(cpu_tick), .halted(halted),
		.settling(settling), .i_mask(i_mask), .sp(sp),
		.irq_take(irq_take), .irq_src(irq_src), .reset_fetch(reset_fetch));
	////////////////////////////////
	task automatic chk(string what, logic [9:0] exp, logic [9:0] got);
		samples_checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask
	// Inputs move 1 ns after the edge to stay clear of sampling
	task automatic cyc(int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic do_op(logic [5:0] o);
		op = o;
		cyc(1);
		op = 6'h00;
	endtask
	task automatic wait_take();
		for (int i = 0; i < 60; i++) begin
			cyc(1);
			if (irq_take === 1'b1) break;
		end
		chk("irq_take", 10'h001, irq_take);
	endtask
	////////////////////////////////
	task automatic t_reset();
		int n;
		n = 0;
		chk("settling", 10'h001, settling);
		chk("sp", 10'h03ff, sp);
		while (reset_fetch !== 1'b1 && n < 40) begin
			cyc(1);
			n++;
		end
		chk("fetch delay", 10'h001, n >= 12 && n <= 16);
		// Fetch request is a single-cycle pulse
		cyc(1);
		chk("reset_fetch", 10'h000, reset_fetch);
		n = 0;
		for (int i = 0; i < 9; i++) begin
			cyc(1);
			n += cpu_tick;
		end
		chk("ticks in nine", 10'h003, n);
		$display("test reset done");
	endtask
	// One idle edge between strobes keeps op from toggling in one step
	task automatic t_call();
		do_op(6'h10);
		chk("sp", 10'h03fd, sp);
		cyc(1);
		do_op(6'h08);
		chk("sp", 10'h03ff, sp);
		cyc(1);
		do_op(6'h01);
		chk("i_mask", 10'h000, i_mask);
		cyc(1);
		do_op(6'h02);
		chk("i_mask", 10'h001, i_mask);
		$display("test call done");
	endtask
	task automatic t_halt_usb();
		do_op(6'h20);
		chk("halted", 10'h001, halted);
		chk("osc_en", 10'h000, osc_en);
		chk("i_mask", 10'h000, i_mask);
		cyc(8);
		// A stray strobe must neither wake nor mask
		do_op(6'h02);
		chk("halted", 10'h001, halted);
		chk("i_mask", 10'h000, i_mask);
		usb = 1'b1;
		cyc(1);
		usb = 1'b0;
		chk("settling", 10'h001, settling);
		wait_take();
		chk("irq_src", 10'h004, irq_src);
		chk("sp", 10'h03fa, sp);
		cyc(6);
		chk("sp", 10'h03ff, sp);
		chk("i_mask", 10'h000, i_mask);
		$display("test halt usb done");
	endtask
	// Line 2 wakes; usb arrives in the first cycle of settling and must wait its turn
	task automatic t_halt_ext();
		lat = 4'h9;
		do_op(6'h20);
		cyc(3);
		ext = 4'h4;
		for (int i = 0; i < 20 && settling !== 1'b1; i++) cyc(1);
		usb = 1'b1;
		cyc(1);
		usb = 1'b0;
		wait_take();
		chk("irq_src", 10'h002, irq_src);
		wait_take();
		chk("irq_src", 10'h004, irq_src);
		chk("sp", 10'h03fa, sp);
		ext = 4'h0;
		cyc(14);
		$display("test halt ext done");
	endtask
	// Reset wakes a halted core and ends in a reset fetch, no interrupt
	task automatic t_halt_reset();
		int n;
		int takes;
		n = 0;
		takes = 0;
		do_op(6'h20);
		chk("halted", 10'h001, halted);
		cyc(4);
		rst_n = 1'b0;
		cyc(2);
		rst_n = 1'b1;
		chk("settling", 10'h001, settling);
		chk("i_mask", 10'h001, i_mask);
		while (reset_fetch !== 1'b1 && n < 40) begin
			cyc(1);
			n++;
			takes += irq_take;
		end
		chk("fetch delay", 10'h001, n >= 12 && n <= 16);
		chk("irq_take", 10'h000, takes);
		$display("test halt reset done");
	endtask
	task automatic end_of_test();
		$display("checked %0d, mismatches %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	////////////////////////////////
	initial begin
		cyc(2);
		rst_n = 1'b1;
		t_reset();
		t_call();
		t_halt_usb();
		t_halt_ext();
		t_halt_reset();
		end_of_test();
	end
	// Tests take about 130 cycles; 2500 means a hang
	initial begin
		#20000;
		error_cnt++;
		end_of_test();
	end
endmodule
